// ### shared/spdc_pkg.sv
// package: constants and carriers for the power-down and clock-edge controller
`default_nettype none
package spdc_pkg;
  // register byte offsets
  localparam logic [7:0] REG_CTRL_OFS = 8'h00;
  localparam logic [7:0] REG_STATUS_OFS = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK_OFS = 8'h0C;
  localparam logic [7:0] REG_SSC_OFS = 8'h10;
  // control field positions
  localparam int CTRL_AUTO_BIT = 0;
  localparam int CTRL_LATCH_EDGE_BIT = 1;
  localparam int CTRL_STROBE_EDGE_BIT = 2;
  localparam int CTRL_SLEEP_SEL_BIT = 3;
  localparam int CTRL_STAGGER_BIT = 4;
  localparam int CTRL_EQ_LSB = 8;
  localparam int CTRL_SSC_EN_BIT = 12;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0007;
  localparam logic [31:0] SSC_RESET = 32'h0000_0000;
  // irq bits
  localparam int IRQ_TX_CLK_LOST = 0;
  localparam int IRQ_TX_CLK_BACK = 1;
  localparam int IRQ_RX_LOCK = 2;
  localparam int IRQ_RX_LOST = 3;
  localparam int IRQ_PD_CHANGE = 4;
  localparam int IRQ_W = 5;
  // timing
  localparam int CLK_HZ = 40_000_000;
  localparam int LINK_PERIOD_NS = 200;
  localparam int CLK_NS = 25;
  // activity timeout: four link periods without an edge
  localparam int IDLE_NS = 4 * LINK_PERIOD_NS;
  localparam int IDLE_CYC = IDLE_NS / CLK_NS;
  localparam int LOCK_EDGES = 8;
  localparam int DATA_W = 21;
  localparam int STAGGER_W = 4;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic clk;
  } spdc_par_t;

  typedef enum logic [3:0] {
    ST_OFF = 4'b0001,
    ST_OSC = 4'b0010,
    ST_LOCKING = 4'b0100,
    ST_RUN = 4'b1000
  } spdc_state_t;
endpackage : spdc_pkg
`default_nettype wire

// ### rtl/spdc_stagger.sv
// lfsr-driven per-bit delay for staggered output transitions
`default_nettype none
module spdc_stagger
(
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic enable_in,
  input wire logic load_in,
  input wire logic [spdc_pkg::DATA_W-1:0] data_in,
  output logic [spdc_pkg::DATA_W-1:0] data_out
);
  logic [15:0] lfsr_r;
  logic [spdc_pkg::DATA_W-1:0] pend_r;
  logic [spdc_pkg::DATA_W-1:0] hold_r;
  logic [spdc_pkg::STAGGER_W-1:0] win_r;
  logic fb;

  assign fb = lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10];
  assign data_out = hold_r;

  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      lfsr_r <= 16'hACE1;
      pend_r <= '0;
      hold_r <= '0;
      win_r <= '0;
    end
    else
    begin
      lfsr_r <= {lfsr_r[14:0], fb};
      if (load_in)
      begin
        pend_r <= data_in;
        win_r <= '1;
        // finish the previous word so no bit skips a strobe
        hold_r <= enable_in ? pend_r : data_in;
      end
      else if (win_r != '0)
      begin
        win_r <= win_r - 1'b1;
        // last slot of the window flushes the rest
        for (int i = 0; i < spdc_pkg::DATA_W; i++)
        begin
          if (lfsr_r[i % 16] || win_r == 1)
          begin
            hold_r[i] <= pend_r[i];
          end
        end
      end
    end
  end
endmodule : spdc_stagger
`default_nettype wire

// ### rtl/spdc_ctrl.sv
// power-down, auto-power and pixel clock edge control with apb registers
//
// Summary of operation
// - a dedicated pin enables the serializer or powers it down.
// - in auto mode a missing pixel clock switches to internal oscillator.
// - when pixel clock returns in auto mode, relock and resume sending.
// - powered-down serializer holds serial outputs static high.
// - deserializer has its own power-down input pin from the system.
// - in auto mode deserializer powers down when serial stream stops.
// - on stream restart, lock, raise lock output, then drive valid data.
// - powered-down deserializer outputs follow the sleep state select bit.
// - receive equalization level comes from a configuration field.
// - staggered outputs spread transitions randomly inside a window.
// - spread spectrum rate and deviation set through control registers.
// - serializer latches on rising pclk if select is 1, else falling.
// - deserializer strobes on rising pclk if select is 1, else falling.
//
// Local design decisions: the APB interface to the registers and the register addresses.
`default_nettype none
module spdc_ctrl
(
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic tx_powerdown_n_pin_in,
  input wire logic rx_powerdown_n_pin_in,
  input wire logic tx_pclk_in,
  input wire logic [spdc_pkg::DATA_W-1:0] tx_data_in,
  input wire logic rx_stream_in,
  input wire logic [spdc_pkg::DATA_W-1:0] rx_data_in,
  output logic tx_serial_out,
  output logic tx_osc_sel_out,
  output logic [spdc_pkg::DATA_W-1:0] tx_latched_out,
  output logic rx_lock_out,
  output spdc_pkg::spdc_par_t rx_par_out,
  output logic [3:0] rx_eq_level_out,
  output logic [15:0] rx_ssc_cfg_out,
  output logic irq_out
);
  // synchronisers for pins and link clocks
  logic [1:0] tx_pd_s_r, rx_pd_s_r, tx_clk_s_r, rx_str_s_r;
  logic [spdc_pkg::DATA_W-1:0] tx_d1_r, tx_d2_r, rx_d1_r, rx_d2_r;
  logic tx_clk_q_r, rx_str_q_r;
  logic [31:0] ctrl_r, ssc_r;
  logic [spdc_pkg::IRQ_W-1:0] irq_stat_r, irq_mask_r, irq_set;
  logic [15:0] tx_idle_r, rx_idle_r;
  logic [3:0] tx_edges_r, rx_edges_r;
  spdc_pkg::spdc_state_t tx_st_r, tx_st_nxt, rx_st_r, rx_st_nxt;
  logic [spdc_pkg::DATA_W-1:0] stag_q;
  logic rx_clk_r;
  logic tx_pd_prev_r, rx_pd_prev_r;

  always_ff @(posedge clock_in)
  begin
    tx_pd_s_r <= {tx_pd_s_r[0], tx_powerdown_n_pin_in};
    rx_pd_s_r <= {rx_pd_s_r[0], rx_powerdown_n_pin_in};
    tx_clk_s_r <= {tx_clk_s_r[0], tx_pclk_in};
    rx_str_s_r <= {rx_str_s_r[0], rx_stream_in};
    tx_d1_r <= tx_data_in;
    tx_d2_r <= tx_d1_r;
    rx_d1_r <= rx_data_in;
    rx_d2_r <= rx_d1_r;
    tx_clk_q_r <= tx_clk_s_r[1];
    rx_str_q_r <= rx_str_s_r[1];
  end

  // decode
  wire tx_pd_n = tx_pd_s_r[1];
  wire rx_pd_n = rx_pd_s_r[1];
  wire auto_mode = ctrl_r[spdc_pkg::CTRL_AUTO_BIT];
  wire latch_rise = ctrl_r[spdc_pkg::CTRL_LATCH_EDGE_BIT];
  wire strobe_rise = ctrl_r[spdc_pkg::CTRL_STROBE_EDGE_BIT];
  wire sleep_sel = ctrl_r[spdc_pkg::CTRL_SLEEP_SEL_BIT];
  wire stagger_en = ctrl_r[spdc_pkg::CTRL_STAGGER_BIT];
  wire tx_rise = tx_clk_s_r[1] & ~tx_clk_q_r;
  wire tx_fall = ~tx_clk_s_r[1] & tx_clk_q_r;
  wire rx_rise = rx_str_s_r[1] & ~rx_str_q_r;
  wire rx_fall = ~rx_str_s_r[1] & rx_str_q_r;
  wire tx_edge = tx_rise | tx_fall;
  wire rx_edge = rx_rise | rx_fall;
  wire tx_clk_lost = tx_idle_r >= 16'(spdc_pkg::IDLE_CYC);
  wire rx_str_lost = rx_idle_r >= 16'(spdc_pkg::IDLE_CYC);
  wire tx_capture = latch_rise ? tx_rise : tx_fall;
  wire rx_strobe = strobe_rise ? rx_rise : rx_fall;

  // activity counters measure pixel clock and stream gaps
  always_ff @(posedge clock_in)
  begin
    if (reset_in || tx_edge)
      tx_idle_r <= '0;
    else if (!tx_clk_lost)
      tx_idle_r <= tx_idle_r + 16'h0001;
    if (reset_in || rx_edge)
      rx_idle_r <= '0;
    else if (!rx_str_lost)
      rx_idle_r <= rx_idle_r + 16'h0001;
  end

  // serializer state
  always_comb
  begin
    tx_st_nxt = tx_st_r;
    case (tx_st_r)
      spdc_pkg::ST_OFF: if (tx_pd_n) tx_st_nxt = spdc_pkg::ST_LOCKING;
      spdc_pkg::ST_OSC: if (!tx_clk_lost) tx_st_nxt = spdc_pkg::ST_LOCKING;
      spdc_pkg::ST_LOCKING:
      begin
        if (tx_clk_lost && auto_mode) tx_st_nxt = spdc_pkg::ST_OSC;
        else if (tx_edges_r == 4'(spdc_pkg::LOCK_EDGES)) tx_st_nxt = spdc_pkg::ST_RUN;
      end
      spdc_pkg::ST_RUN: if (tx_clk_lost) tx_st_nxt = auto_mode ? spdc_pkg::ST_OSC
                                                          : spdc_pkg::ST_LOCKING;
      default: tx_st_nxt = spdc_pkg::ST_OFF;
    endcase
    if (!tx_pd_n) tx_st_nxt = spdc_pkg::ST_OFF;
  end

  // deserializer state
  always_comb
  begin
    rx_st_nxt = rx_st_r;
    case (rx_st_r)
      spdc_pkg::ST_OFF:
        if (rx_pd_n && !rx_str_lost) rx_st_nxt = spdc_pkg::ST_LOCKING;
      spdc_pkg::ST_LOCKING:
      begin
        if (rx_str_lost) rx_st_nxt = spdc_pkg::ST_OFF;
        else if (rx_edges_r == 4'(spdc_pkg::LOCK_EDGES)) rx_st_nxt = spdc_pkg::ST_RUN;
      end
      spdc_pkg::ST_RUN:
        if (rx_str_lost) rx_st_nxt = auto_mode ? spdc_pkg::ST_OFF : spdc_pkg::ST_LOCKING;
      default: rx_st_nxt = spdc_pkg::ST_OFF;
    endcase
    if (!rx_pd_n) rx_st_nxt = spdc_pkg::ST_OFF;
  end

  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      tx_st_r <= spdc_pkg::ST_OFF;
      rx_st_r <= spdc_pkg::ST_OFF;
      tx_edges_r <= '0;
      rx_edges_r <= '0;
    end
    else
    begin
      tx_st_r <= tx_st_nxt;
      rx_st_r <= rx_st_nxt;
      if (tx_st_r != spdc_pkg::ST_LOCKING) tx_edges_r <= '0;
      else if (tx_rise) tx_edges_r <= tx_edges_r + 4'h1;
      if (rx_st_r != spdc_pkg::ST_LOCKING) rx_edges_r <= '0;
      else if (rx_rise) rx_edges_r <= rx_edges_r + 4'h1;
    end
  end

  wire tx_off = tx_st_r == spdc_pkg::ST_OFF;
  wire rx_run = rx_st_r == spdc_pkg::ST_RUN;
  wire rx_off = rx_st_r == spdc_pkg::ST_OFF;
  wire rx_load = rx_run & rx_strobe;

  spdc_stagger u_stagger
  (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .enable_in(stagger_en),
    .load_in(rx_load),
    .data_in(rx_d2_r),
    .data_out(stag_q)
  );

  // datapath outputs
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      tx_serial_out <= 1'b1;
      tx_osc_sel_out <= 1'b0;
      tx_latched_out <= '0;
      rx_lock_out <= 1'b0;
      rx_par_out <= '0;
      rx_clk_r <= 1'b0;
    end
    else
    begin
      tx_serial_out <= tx_off ? 1'b1 : ^tx_latched_out ^ tx_clk_s_r[1];
      tx_osc_sel_out <= tx_st_r == spdc_pkg::ST_OSC;
      if (tx_st_r == spdc_pkg::ST_RUN && tx_capture) tx_latched_out <= tx_d2_r;
      rx_lock_out <= rx_run;
      if (rx_load) rx_clk_r <= ~rx_clk_r;
      if (rx_off) rx_par_out <= sleep_sel ? '1 : '0;
      else if (rx_run) rx_par_out <= {stag_q, rx_clk_r};
      else rx_par_out <= '0;
    end
  end

  // events
  always_comb
  begin
    irq_set = '0;
    irq_set[spdc_pkg::IRQ_TX_CLK_LOST] = tx_st_nxt == spdc_pkg::ST_OSC &&
                                         tx_st_r != spdc_pkg::ST_OSC;
    irq_set[spdc_pkg::IRQ_TX_CLK_BACK] = tx_st_nxt == spdc_pkg::ST_RUN &&
                                         tx_st_r != spdc_pkg::ST_RUN;
    irq_set[spdc_pkg::IRQ_RX_LOCK] = rx_st_nxt == spdc_pkg::ST_RUN && !rx_run;
    irq_set[spdc_pkg::IRQ_RX_LOST] = rx_run && rx_st_nxt != spdc_pkg::ST_RUN;
    irq_set[spdc_pkg::IRQ_PD_CHANGE] = (tx_pd_n != tx_pd_prev_r) ||
                                       (rx_pd_n != rx_pd_prev_r);
  end

  // apb slave, zero wait states
  wire wr_en = psel_in & penable_in & pwrite_in;
  wire hit_ctrl = paddr_in == spdc_pkg::REG_CTRL_OFS;
  wire hit_stat = paddr_in == spdc_pkg::REG_STATUS_OFS;
  wire hit_irqs = paddr_in == spdc_pkg::REG_IRQ_STAT_OFS;
  wire hit_mask = paddr_in == spdc_pkg::REG_IRQ_MASK_OFS;
  wire hit_ssc = paddr_in == spdc_pkg::REG_SSC_OFS;
  wire hit_any = hit_ctrl | hit_stat | hit_irqs | hit_mask | hit_ssc;
  wire [31:0] rd_mux = hit_ctrl ? ctrl_r :
                       hit_stat ? {24'h0, rx_st_r, tx_st_r} :
                       hit_irqs ? 32'(irq_stat_r) :
                       hit_mask ? 32'(irq_mask_r) :
                       hit_ssc ? ssc_r : 32'h0000_0000;
  wire [spdc_pkg::IRQ_W-1:0] w1c = (wr_en && hit_irqs) ?
                                   pwdata_in[spdc_pkg::IRQ_W-1:0] : '0;

  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      ctrl_r <= spdc_pkg::CTRL_RESET;
      ssc_r <= spdc_pkg::SSC_RESET;
      irq_stat_r <= '0;
      irq_mask_r <= '0;
      // track the pin level so release brings no false change event
      tx_pd_prev_r <= tx_pd_n;
      rx_pd_prev_r <= rx_pd_n;
      prdata_out <= '0;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      irq_out <= 1'b0;
    end
    else
    begin
      tx_pd_prev_r <= tx_pd_n;
      rx_pd_prev_r <= rx_pd_n;
      if (wr_en && hit_ctrl) ctrl_r <= pwdata_in;
      if (wr_en && hit_ssc) ssc_r <= {16'h0000, pwdata_in[15:0]};
      if (wr_en && hit_mask) irq_mask_r <= pwdata_in[spdc_pkg::IRQ_W-1:0];
      irq_stat_r <= (irq_stat_r & ~w1c) | irq_set;
      irq_out <= |(((irq_stat_r & ~w1c) | irq_set) & irq_mask_r);
      pready_out <= psel_in & ~penable_in;
      pslverr_out <= psel_in & ~penable_in & ~hit_any;
      prdata_out <= (psel_in & ~penable_in & ~pwrite_in) ? rd_mux : 32'h0000_0000;
    end
  end

  assign rx_eq_level_out = ctrl_r[spdc_pkg::CTRL_EQ_LSB +: 4];
  assign rx_ssc_cfg_out = ctrl_r[spdc_pkg::CTRL_SSC_EN_BIT] ? ssc_r[15:0] : 16'h0000;
endmodule : spdc_ctrl
`default_nettype wire

// ### verif/spdc_ctrl_monitor.sv
// checker for power-down, auto-power and config outputs
`default_nettype none
module spdc_ctrl_monitor
(
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic pready_out,
  input wire logic tx_powerdown_n_pin_in,
  input wire logic rx_powerdown_n_pin_in,
  input wire logic tx_pclk_in,
  input wire logic rx_stream_in,
  input wire logic tx_serial_out,
  input wire logic tx_osc_sel_out,
  input wire logic rx_lock_out,
  input wire spdc_pkg::spdc_par_t rx_par_out,
  input wire logic [3:0] rx_eq_level_out,
  input wire logic [15:0] rx_ssc_cfg_out,
  input wire logic irq_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);
  logic auto_r, sleep_r, pclk_d_r, strm_d_r;
  logic [5:0] tq_r, rq_r;
  wire acc = psel_in && penable_in && pready_out && pwrite_in;
  wire wr_ctrl = acc && paddr_in == spdc_pkg::REG_CTRL_OFS;
  wire wr_mask = acc && paddr_in == spdc_pkg::REG_IRQ_MASK_OFS;
  wire tx_busy = !tx_powerdown_n_pin_in || tx_pclk_in != pclk_d_r;
  // quiet counters, saturating
  always_ff @(posedge clock_in)
  begin
    pclk_d_r <= tx_pclk_in;
    strm_d_r <= rx_stream_in;
    tq_r <= (reset_in || tx_busy) ? 6'h00 : tq_r + {5'h00, tq_r != 6'h3F};
    rq_r <= (reset_in || rx_stream_in != strm_d_r) ? 6'h00 : rq_r + {5'h00, rq_r != 6'h3F};
    auto_r <= reset_in ? spdc_pkg::CTRL_RESET[0] : wr_ctrl ? pwdata_in[0] : auto_r;
    sleep_r <= reset_in ? spdc_pkg::CTRL_RESET[3] : wr_ctrl ? pwdata_in[3] : sleep_r;
  end
  a_ser_static_high:
    assert property ((!tx_powerdown_n_pin_in) [*6] |-> tx_serial_out)
    else $error("serial out not high in power-down");
  a_rx_pd_unlock:
    assert property ((!rx_powerdown_n_pin_in) [*6] |-> !rx_lock_out)
    else $error("lock high in power-down");
  a_sleep_level:
    assert property ((!rx_powerdown_n_pin_in) [*6] ##0 (sleep_r == $past(sleep_r, 3))
      |-> rx_par_out == {(spdc_pkg::DATA_W + 1){sleep_r}})
    else $error("sleep output level wrong");
  a_osc_on_loss:
    assert property (tq_r == 6'h2D && auto_r |-> tx_osc_sel_out)
    else $error("no oscillator after clock loss");
  a_pclk_relock:
    assert property (tx_osc_sel_out && auto_r && !tx_busy == 1'b0 && tx_powerdown_n_pin_in
      |-> ##[1:120] !tx_osc_sel_out)
    else $error("no relock to pixel clock");
  a_idle_unlock:
    assert property (rq_r == 6'h2D |-> !rx_lock_out)
    else $error("lock held without stream");
  a_eq_field:
    assert property (wr_ctrl |=> rx_eq_level_out == $past(pwdata_in[11:8]))
    else $error("equalization level wrong");
  a_ssc_gate:
    assert property (wr_ctrl && !pwdata_in[spdc_pkg::CTRL_SSC_EN_BIT] |=> rx_ssc_cfg_out == 16'h0000)
    else $error("ssc config not gated");
  a_irq_masked:
    assert property (wr_mask && pwdata_in[4:0] == 5'h00 |=> ##1 !irq_out)
    else $error("irq high with all masked");
  c_osc: cover property ($rose(tx_osc_sel_out));
  c_lock: cover property ($rose(rx_lock_out));
  c_irq: cover property ($rose(irq_out));
endmodule : spdc_ctrl_monitor
bind spdc_ctrl spdc_ctrl_monitor u_mon
(
  .clock_in(clock_in), .reset_in(reset_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pready_out(pready_out),
  .tx_powerdown_n_pin_in(tx_powerdown_n_pin_in), .rx_powerdown_n_pin_in(rx_powerdown_n_pin_in),
  .tx_pclk_in(tx_pclk_in), .rx_stream_in(rx_stream_in), .tx_serial_out(tx_serial_out),
  .tx_osc_sel_out(tx_osc_sel_out), .rx_lock_out(rx_lock_out), .rx_par_out(rx_par_out),
  .rx_eq_level_out(rx_eq_level_out), .rx_ssc_cfg_out(rx_ssc_cfg_out), .irq_out(irq_out)
);
`default_nettype wire

// ### verif/spdc_far_model.sv
// far-side source: clock plus counting data, still when off
`default_nettype none
module spdc_far_model
#(
  parameter int PHASE_NS = 0
)
(
  input wire logic on_in,
  output logic clk_out,
  output logic [spdc_pkg::DATA_W-1:0] data_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // data moves mid-phase so each edge sees a distinct value
  initial
  begin
    clk_out = 1'b0;
    data_out = '0;
    #PHASE_NS;
    forever
    begin
      if (on_in)
      begin
        clk_out = 1'b1;
        #50 data_out = data_out + 1'b1;
        #50 clk_out = 1'b0;
        #50 data_out = data_out + 1'b1;
        #50;
      end
      else
        #200;
    end
  end
endmodule : spdc_far_model
`default_nettype wire

// ### verif/test_spdc_ctrl.sv
// self-checking bench for the power-down and clock-edge controller
`default_nettype none
module test_spdc_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock_in = 1'b0;
  logic reset_in = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd_v;
  logic tx_pd_n = 1'b0, rx_pd_n = 1'b0, pix_on = 1'b0, lnk_on = 1'b0;
  logic pclk, strm, pready, pslverr, er_v, tx_ser, osc, lock, irq;
  logic [spdc_pkg::DATA_W-1:0] tx_d, rx_d, latched;
  spdc_pkg::spdc_par_t par;
  logic [3:0] eq;
  logic [15:0] ssc;
  int bad_count = 0, n_compared = 0;
  spdc_far_model #(.PHASE_NS(13)) u_pix (.on_in(pix_on), .clk_out(pclk), .data_out(tx_d));
  spdc_far_model #(.PHASE_NS(37)) u_lnk (.on_in(lnk_on), .clk_out(strm), .data_out(rx_d));
  spdc_ctrl dut
  (
    .clock_in(clock_in), .reset_in(reset_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .tx_powerdown_n_pin_in(tx_pd_n),
    .rx_powerdown_n_pin_in(rx_pd_n), .tx_pclk_in(pclk), .tx_data_in(tx_d),
    .rx_stream_in(strm), .rx_data_in(rx_d), .tx_serial_out(tx_ser), .tx_osc_sel_out(osc),
    .tx_latched_out(latched), .rx_lock_out(lock), .rx_par_out(par),
    .rx_eq_level_out(eq), .rx_ssc_cfg_out(ssc), .irq_out(irq)
  );
  initial
  begin
    forever #12.5 clock_in = ~clock_in;
  end
  task close_out;
    if (bad_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  task wt(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask : wt
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in);
    penable <= 1'b1;
    @(posedge clock_in);
    while (pready !== 1'b1) @(posedge clock_in);
    rd_v = prdata;
    er_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task t_regs;
    apb(1'b0, spdc_pkg::REG_CTRL_OFS, 32'h0);
    chk(rd_v, spdc_pkg::CTRL_RESET);
    apb(1'b0, spdc_pkg::REG_SSC_OFS, 32'h0);
    chk(rd_v, spdc_pkg::SSC_RESET);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, er_v}, 32'h1);
    chk(rd_v, 32'h0);
  endtask : t_regs
  task t_ser_pd;
    wt(6);
    chk({31'h0, tx_ser}, 32'h1);
    apb(1'b0, spdc_pkg::REG_STATUS_OFS, 32'h0);
    chk(rd_v & 32'h0F, 32'(spdc_pkg::ST_OFF));
    @(posedge clock_in) tx_pd_n <= 1'b1;
    @(posedge clock_in) rx_pd_n <= 1'b1;
  endtask : t_ser_pd
  task t_edges;
    for (int s = 0; s < 2; s++)
    begin
      apb(1'b1, spdc_pkg::REG_CTRL_OFS, 32'(s) * 32'h16);
      @(posedge clock_in) pix_on <= 1'b1;
      lnk_on <= 1'b1;
      wt(120);
      chk({31'h0, lock}, 32'h1);
      @(posedge clock_in) pix_on <= 1'b0;
      lnk_on <= 1'b0;
      wt(24);
      chk(32'(latched), 32'(tx_d - 1'b1 - s[0]));
      chk(32'(par.data), 32'(rx_d - 1'b1 - s[0]));
    end
  endtask : t_edges
  task t_tx_auto;
    apb(1'b1, spdc_pkg::REG_IRQ_MASK_OFS, 32'h1);
    apb(1'b1, spdc_pkg::REG_CTRL_OFS, 32'h1);
    wt(60);
    chk({31'h0, osc}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    @(posedge clock_in) pix_on <= 1'b1;
    for (int i = 0; i < 200 && osc !== 1'b0; i++) wt(1);
    chk({31'h0, osc}, 32'h0);
    wt(80);
    apb(1'b0, spdc_pkg::REG_STATUS_OFS, 32'h0);
    chk(rd_v & 32'h0F, 32'(spdc_pkg::ST_RUN));
    apb(1'b1, spdc_pkg::REG_IRQ_MASK_OFS, 32'h0);
    wt(2);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, spdc_pkg::REG_IRQ_STAT_OFS, 32'h0);
    chk(rd_v & 32'h1, 32'h1);
    apb(1'b1, spdc_pkg::REG_IRQ_STAT_OFS, 32'h1);
    apb(1'b0, spdc_pkg::REG_IRQ_STAT_OFS, 32'h0);
    chk(rd_v & 32'h1, 32'h0);
    @(posedge clock_in) pix_on <= 1'b0;
  endtask : t_tx_auto
  task t_rx_auto;
    @(posedge clock_in) lnk_on <= 1'b1;
    for (int i = 0; i < 300 && lock !== 1'b1; i++) wt(1);
    chk({31'h0, lock}, 32'h1);
    @(posedge clock_in) lnk_on <= 1'b0;
    wt(60);
    chk({31'h0, lock}, 32'h0);
    apb(1'b0, spdc_pkg::REG_STATUS_OFS, 32'h0);
    chk(rd_v & 32'hF0, 32'(spdc_pkg::ST_OFF) << 4);
  endtask : t_rx_auto
  task t_sleep;
    @(posedge clock_in) lnk_on <= 1'b1;
    for (int i = 0; i < 300 && lock !== 1'b1; i++) wt(1);
    chk({31'h0, lock}, 32'h1);
    @(posedge clock_in) rx_pd_n <= 1'b0;
    for (int s = 0; s < 2; s++)
    begin
      apb(1'b1, spdc_pkg::REG_CTRL_OFS, 32'(s) * 32'h8);
      wt(8);
      chk(32'(par), (s == 1) ? 32'h003F_FFFF : 32'h0);
    end
    chk({31'h0, lock}, 32'h0);
    apb(1'b0, spdc_pkg::REG_STATUS_OFS, 32'h0);
    chk(rd_v & 32'hF0, 32'(spdc_pkg::ST_OFF) << 4);
    apb(1'b0, spdc_pkg::REG_IRQ_STAT_OFS, 32'h0);
    chk(rd_v & 32'h1C, 32'h1C);
    @(posedge clock_in) lnk_on <= 1'b0;
  endtask : t_sleep
  task t_cfg;
    apb(1'b1, spdc_pkg::REG_SSC_OFS, 32'h0000_1234);
    apb(1'b1, spdc_pkg::REG_CTRL_OFS, 32'h0000_1A00);
    wt(2);
    chk({28'h0, eq}, 32'hA);
    chk({16'h0, ssc}, 32'h1234);
    apb(1'b1, spdc_pkg::REG_CTRL_OFS, 32'h0000_0500);
    wt(2);
    chk({28'h0, eq}, 32'h5);
    chk({16'h0, ssc}, 32'h0);
  endtask : t_cfg
  initial
  begin
    repeat (6) @(posedge clock_in);
    reset_in <= 1'b0;
    t_regs;
    t_ser_pd;
    t_edges;
    t_tx_auto;
    t_rx_auto;
    t_sleep;
    t_cfg;
    close_out;
  end
  initial
  begin
    #200000;
    bad_count++;
    close_out;
  end
endmodule : test_spdc_ctrl
`default_nettype wire
